// [shared/bit_manip_pkg.sv]
// Purpose: Shared constants and types for the bit manipulation unit
// Assumes: Byte-wide operands, 3-bit bit positions
// Notes: Flag positions follow the condition code register layout
package bit_manip_pkg;
  localparam int DATA_W = 8;
  localparam int POS_W = 3;
  localparam int CCR_W = 8;
  // Flag positions inside the condition code register
  localparam int CARRY_POS = 0;
  localparam int ZERO_POS = 2;
  localparam logic [CCR_W-1:0] CCR_RESET = 8'h80;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  typedef enum logic [3:0] {
    set_bit_op,
    clear_bit_op,
    invert_bit_op,
    test_bit_op,
    carry_and_bit_op,
    carry_and_inverted_bit_op,
    carry_or_bit_op,
    carry_or_inverted_bit_op,
    carry_xor_bit_op,
    carry_xor_inverted_bit_op,
    load_bit_to_carry_op,
    load_inverted_bit_to_carry_op,
    store_carry_to_bit_op,
    store_inverted_carry_to_bit_op
  } bit_op_type;

  typedef enum {
    idle_st,
    mem_read_st,
    mem_write_st
  } seq_state_type;
endpackage : bit_manip_pkg

// [src/bit_alu.sv]
// Purpose: Combinational bit operation core
// Assumes: Caller has already resolved the bit position
// Notes: Pure function of its inputs
`timescale 1ns/1ps
module bit_alu (
  // Operation
  input wire bit_manip_pkg::bit_op_type op,
  input wire logic [2:0] bit_pos,
  // Operand and flags
  input wire logic [7:0] operand,
  input wire logic carry_in,
  // Results
  output logic [7:0] result,
  output logic write_operand,
  output logic carry_out,
  output logic write_carry,
  output logic zero_out,
  output logic write_zero
);
  import bit_manip_pkg::*;
  logic sel_bit;
  logic [DATA_W-1:0] mask;

  always_comb begin
    sel_bit = operand[bit_pos];
    mask = 8'h01 << bit_pos;
    result = operand;
    write_operand = 1'b0;
    carry_out = carry_in;
    write_carry = 1'b0;
    zero_out = 1'b0;
    write_zero = 1'b0;
    // Only the targeted flag is ever strobed
    case (op)
      set_bit_op: begin
        result = operand | mask;
        write_operand = 1'b1;
      end
      clear_bit_op: begin
        result = operand & ~mask;
        write_operand = 1'b1;
      end
      invert_bit_op: begin
        result = operand ^ mask;
        write_operand = 1'b1;
      end
      test_bit_op: begin
        zero_out = ~sel_bit;
        write_zero = 1'b1;
      end
      carry_and_bit_op: begin
        carry_out = carry_in & sel_bit;
        write_carry = 1'b1;
      end
      carry_or_bit_op: begin
        carry_out = carry_in | sel_bit;
        write_carry = 1'b1;
      end
      carry_xor_bit_op: begin
        carry_out = carry_in ^ sel_bit;
        write_carry = 1'b1;
      end
      carry_and_inverted_bit_op: begin
        carry_out = carry_in & ~sel_bit;
        write_carry = 1'b1;
      end
      carry_or_inverted_bit_op: begin
        carry_out = carry_in | ~sel_bit;
        write_carry = 1'b1;
      end
      carry_xor_inverted_bit_op: begin
        carry_out = carry_in ^ ~sel_bit;
        write_carry = 1'b1;
      end
      load_bit_to_carry_op: begin
        carry_out = sel_bit;
        write_carry = 1'b1;
      end
      load_inverted_bit_to_carry_op: begin
        carry_out = ~sel_bit;
        write_carry = 1'b1;
      end
      store_carry_to_bit_op: begin
        result = carry_in ? (operand | mask) : (operand & ~mask);
        write_operand = 1'b1;
      end
      store_inverted_carry_to_bit_op: begin
        result = carry_in ? (operand & ~mask) : (operand | mask);
        write_operand = 1'b1;
      end
      default: begin
        result = operand;
      end
    endcase
  end
endmodule : bit_alu

// [src/bit_manip_unit.sv]
// Purpose: Execution datapath for byte-wide single-bit instructions
// Assumes: Decoded operands from the core, memory port answers one cycle after a read strobe
// Notes: One instruction in flight; start is ignored while busy
`timescale 1ns/1ps
module bit_manip_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Instruction issue
  input wire logic start,
  input wire bit_manip_pkg::bit_op_type op,
  input wire logic use_reg_pos,
  input wire logic [2:0] imm_pos,
  input wire logic [7:0] pos_reg_value,
  input wire logic operand_in_mem,
  input wire logic [7:0] reg_operand,
  input wire logic [15:0] mem_addr,
  // Condition code register as held by the core
  input wire logic [7:0] ccr_in,
  // Memory port
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Results
  output logic busy,
  output logic done,
  output logic reg_we,
  output logic [7:0] reg_result,
  output logic ccr_we,
  output logic [7:0] ccr_out
);
  import bit_manip_pkg::*;

  seq_state_type state_reg;
  seq_state_type state_next;
  bit_op_type op_reg;
  logic [POS_W-1:0] pos_reg;
  logic [15:0] addr_reg;
  logic [CCR_W-1:0] ccr_reg;
  logic [POS_W-1:0] pos_sel;
  logic pos_from_reg;
  logic [DATA_W-1:0] alu_operand;
  logic [DATA_W-1:0] alu_result;
  logic alu_wr_op;
  logic alu_carry;
  logic alu_wr_carry;
  logic alu_zero;
  logic alu_wr_zero;
  logic [CCR_W-1:0] ccr_new;
  logic finish_now;
  logic reg_path;

  // Register position allowed only for set, clear, invert, test
  always_comb begin
    case (op)
      set_bit_op, clear_bit_op, invert_bit_op, test_bit_op: pos_from_reg = use_reg_pos;
      default: pos_from_reg = 1'b0;
    endcase
  end

  assign pos_sel = pos_from_reg ? pos_reg_value[POS_W-1:0] : imm_pos;
  assign reg_path = (state_reg == idle_st) && start && !operand_in_mem;

  // Memory phase reuses the latched op and position
  always_comb begin
    alu_operand = reg_path ? reg_operand : mem_rdata;
  end

  bit_alu u_alu (
    .op(reg_path ? op : op_reg),
    .bit_pos(reg_path ? pos_sel : pos_reg),
    .operand(alu_operand),
    .carry_in(ccr_in[CARRY_POS]),
    .result(alu_result),
    .write_operand(alu_wr_op),
    .carry_out(alu_carry),
    .write_carry(alu_wr_carry),
    .zero_out(alu_zero),
    .write_zero(alu_wr_zero)
  );

  // Untouched flags pass through from the core copy
  always_comb begin
    ccr_new = ccr_in;
    if (alu_wr_carry) begin
      ccr_new[CARRY_POS] = alu_carry;
    end
    if (alu_wr_zero) begin
      ccr_new[ZERO_POS] = alu_zero;
    end
  end

  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      idle_st: begin
        if (start && operand_in_mem) begin
          state_next = mem_read_st;
        end
      end
      mem_read_st: state_next = mem_write_st;
      mem_write_st: state_next = idle_st;
      default: state_next = idle_st;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= idle_st;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      op_reg <= set_bit_op;
      pos_reg <= 3'h0;
      addr_reg <= 16'h0000;
    end else if (state_reg == idle_st && start) begin
      op_reg <= op;
      pos_reg <= pos_sel;
      addr_reg <= mem_addr;
    end
  end

  // Read strobe one cycle; data assumed on mem_rdata the following cycle
  assign mem_rd = (state_reg == mem_read_st);
  assign mem_addr_out = addr_reg;
  assign busy = (state_reg != idle_st);
  assign finish_now = reg_path || (state_reg == mem_write_st);

  // Byte written back only for ops that change the operand; flag-only ops leave mem_wr low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_wr <= 1'b0;
      mem_wdata <= DATA_RESET;
    end else begin
      mem_wr <= (state_reg == mem_write_st) && alu_wr_op;
      mem_wdata <= (state_reg == mem_write_st) ? alu_result : mem_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      done <= 1'b0;
      reg_we <= 1'b0;
      reg_result <= DATA_RESET;
      ccr_we <= 1'b0;
      ccr_reg <= CCR_RESET;
    end else begin
      done <= finish_now;
      reg_we <= reg_path && alu_wr_op;
      reg_result <= reg_path ? alu_result : reg_result;
      ccr_we <= finish_now && (alu_wr_carry || alu_wr_zero);
      ccr_reg <= finish_now ? ccr_new : ccr_reg;
    end
  end

  assign ccr_out = ccr_reg;
endmodule : bit_manip_unit

// [tb/bit_manip_unit_assertions.sv]
// Purpose: Port-level checks for the bit manipulation unit
// Assumes: Bound to bit_manip_unit
// Notes: Position checks use immediate-position register ops only
`timescale 1ns/1ps
module bit_manip_unit_assertions
  import bit_manip_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Issue
  input wire logic start,
  input wire bit_op_type op,
  input wire logic use_reg_pos,
  input wire logic [2:0] imm_pos,
  input wire logic operand_in_mem,
  input wire logic [7:0] reg_operand,
  input wire logic [7:0] ccr_in,
  // Outputs
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic busy,
  input wire logic done,
  input wire logic reg_we,
  input wire logic ccr_we,
  input wire logic [7:0] ccr_out
);
  wire logic take_reg = start && !busy && !operand_in_mem;
  wire logic take_mem = start && !busy && operand_in_mem;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence mem_walk;
    mem_rd && busy ##1 busy && !mem_rd ##1 done && !busy;
  endsequence
  a_reg_answer: assert property (take_reg |=> done && !busy)
    else $error("register op late");
  a_mem_sequence: assert property (take_mem |=> mem_walk)
    else $error("memory sequence broken");
  a_read_busy: assert property (mem_rd |-> busy)
    else $error("read outside sequence");
  a_write_single: assert property (mem_wr |=> !mem_wr)
    else $error("write pulse too long");
  a_flags_quiet: assert property (take_reg && (op <= invert_bit_op || op >= store_carry_to_bit_op)
    |=> reg_we && !ccr_we)
    else $error("flags touched");
  a_test_zero: assert property (take_reg && op == test_bit_op && !use_reg_pos
    |=> ccr_out[ZERO_POS] == !$past(reg_operand[imm_pos]))
    else $error("zero flag wrong");
  a_load_carry: assert property (take_reg && op == load_bit_to_carry_op
    |=> ccr_out[CARRY_POS] == $past(reg_operand[imm_pos]))
    else $error("carry load wrong");
  a_ccr_upper: assert property (ccr_we && !$past(busy) |-> ccr_out[7:3] == $past(ccr_in[7:3]))
    else $error("untouched flags changed");
endmodule : bit_manip_unit_assertions

// [tb/testbench.sv]
// Purpose: Random and corner tests of the bit manipulation unit
// Assumes: Inputs change on the falling edge
// Notes: First 14 ops walk every code; start stays high across register ops except in random idle gaps and drops once a memory op is busy
`timescale 1ns/1ps
module testbench;
  import bit_manip_pkg::*;
  logic ref_clk = 0, rst_b = 0, start = 0, use_reg_pos = 0, operand_in_mem = 0;
  bit_op_type op = set_bit_op;
  logic [2:0] imm_pos = 0;
  logic [7:0] pos_reg_value = 0, reg_operand = 0, ccr_in = 0, mem_rdata = 0;
  logic [15:0] mem_addr = 0, mem_addr_out;
  logic mem_rd, mem_wr, busy, done, reg_we, ccr_we;
  logic [7:0] mem_wdata, reg_result, ccr_out;
  logic [16:0] e;
  int fail_count = 0, num_checks = 0;
  always #10 ref_clk = ~ref_clk;
  bit_manip_unit bit_manip_unit_i (.ref_clk, .rst_b, .start, .op, .use_reg_pos, .imm_pos,
    .pos_reg_value, .operand_in_mem, .reg_operand, .mem_addr, .ccr_in, .mem_rd, .mem_wr,
    .mem_addr_out, .mem_wdata, .mem_rdata, .busy, .done, .reg_we, .reg_result, .ccr_we, .ccr_out);
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // Returns writes-operand flag, new flags, new byte
  function automatic logic [16:0] model(bit_op_type o, logic [7:0] d, logic [2:0] p, logic [7:0] f);
    logic [7:0] r;
    logic b;
    r = d;
    b = d[p];
    case (o)
      set_bit_op: r[p] = 1'b1;
      clear_bit_op: r[p] = 1'b0;
      invert_bit_op: r[p] = !b;
      test_bit_op: f[ZERO_POS] = !b;
      carry_and_bit_op: f[CARRY_POS] &= b;
      carry_or_bit_op: f[CARRY_POS] |= b;
      carry_xor_bit_op: f[CARRY_POS] ^= b;
      carry_and_inverted_bit_op: f[CARRY_POS] &= !b;
      carry_or_inverted_bit_op: f[CARRY_POS] |= !b;
      carry_xor_inverted_bit_op: f[CARRY_POS] ^= !b;
      load_bit_to_carry_op: f[CARRY_POS] = b;
      load_inverted_bit_to_carry_op: f[CARRY_POS] = !b;
      store_carry_to_bit_op: r[p] = f[CARRY_POS];
      default: r[p] = !f[CARRY_POS];
    endcase
    return {o <= invert_bit_op || o >= store_carry_to_bit_op, f, r};
  endfunction : model
  initial begin : watchdog
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    conclude();
  end
  initial begin : main
    logic m, wo;
    logic [2:0] p;
    repeat (12) @(negedge ref_clk);
    chk("rst", {ccr_out, reg_result, mem_wdata, done}, {CCR_RESET, DATA_RESET, DATA_RESET, 1'b0});
    rst_b = 1;
    void'($urandom(77));
    for (int i = 0; i < 400; i++) begin
      op = bit_op_type'(i < 14 ? i : $urandom_range(13));
      m = i >= 14 && $urandom_range(1);
      operand_in_mem = m;
      use_reg_pos = $urandom_range(1);
      {pos_reg_value, reg_operand, ccr_in, mem_rdata} = $urandom;
      {imm_pos, mem_addr} = 19'($urandom);
      p = use_reg_pos && op <= test_bit_op ? pos_reg_value[2:0] : imm_pos;
      e = model(op, m ? mem_rdata : reg_operand, p, ccr_in);
      wo = e[16];
      start = 1;
      @(negedge ref_clk);
      if (m) begin
        chk("rd", {mem_rd, busy, mem_addr_out}, {2'b11, mem_addr});
        start = 0;
        repeat (2) @(negedge ref_clk);
        chk("wr", {mem_wr, wo ? mem_wdata : e[7:0]}, {wo, e[7:0]});
      end else chk("reg", {reg_we, wo ? reg_result : e[7:0]}, {wo, e[7:0]});
      chk("flags", {done, ccr_we, wo ? ccr_out : e[15:8]}, {1'b1, !wo, e[15:8]});
      if ($urandom_range(3) == 0) begin
        start = 0;
        @(negedge ref_clk);
        chk("idle", {done, reg_we, ccr_we, mem_wr}, 0);
      end
    end
    conclude();
  end
endmodule : testbench
bind bit_manip_unit bit_manip_unit_assertions bit_manip_unit_assertions_i (.ref_clk, .rst_b, .start, .op,
  .use_reg_pos, .imm_pos, .operand_in_mem, .reg_operand, .ccr_in, .mem_rd, .mem_wr, .busy, .done,
  .reg_we, .ccr_we, .ccr_out);
